/* File: pcie_descriptor_ring_dma.v */
/*
  descriptor register file, channel scheduler and interrupt hookup.
  assumes tlp building and register transport sit outside, on ref_clk.
*/
`timescale 1ns/1ps
`include "dma_defs.vh"

module pcie_descriptor_ring_dma #(
  parameter CHAN_COUNT = `CHAN_COUNT_DEFAULT,
  parameter IRQ_VECTORS = `IRQ_VECTORS_DEFAULT,
  parameter IRQ_W = 3
) (
  input wire ref_clk,
  input wire rstn,
  input wire reg_wr,
  input wire reg_rd,
  input wire [11:0] reg_addr,
  input wire [127:0] reg_wdata,
  output reg [127:0] reg_rdata,
  output reg reg_rvalid,
  input wire [CHAN_COUNT-2:0] upstream_fifo_nearly_empty,
  input wire host_to_card_fifo_ready,
  output reg tlp_req_valid,
  output reg [2:0] tlp_req_chan,
  output reg [63:0] tlp_req_addr,
  output reg [10:0] tlp_req_words,
  output reg tlp_req_h2c,
  input wire tlp_done,
  output wire irq_valid,
  output wire [IRQ_W-1:0] irq_vector
);
  localparam NDESC = CHAN_COUNT + 1;
  localparam NC2H = CHAN_COUNT - 1;

  reg [63:0] base_r [0:`MAX_DESC-1];
  reg [63:0] limit_r [0:`MAX_DESC-1];
  reg [63:0] hptr_r [0:`MAX_DESC-1];
  reg ring_r [0:`MAX_DESC-1];
  reg [10:0] size_r [0:`MAX_DESC-1];
  reg [7:0] en_r;
  reg [7:0] start_r;
  reg busy_r;
  reg [2:0] cur_r;
  reg inject_r;
  reg [IRQ_W-1:0] inject_vec_r;

  wire [63:0] pos_w [0:`MAX_DESC-1];
  wire [NDESC-1:0] epar_w;
  wire [NDESC-1:0] hpar_w;
  wire [NDESC-1:0] done_w;
  wire [NDESC-1:0] finish_w;
  wire [NDESC-1:0] allow_w;
  wire [NDESC-1:0] src_ok;
  wire [7:0] finish_mask;

  wire win_hit;
  wire ctl_hit;
  wire prog_hit;
  wire [2:0] dsel;
  wire [2:0] psel;

  reg found;
  reg [2:0] pick;
  integer i;
  integer j;
  genvar g;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  assign dsel = reg_addr[7:5];
  assign psel = reg_addr[6:4];
  assign win_hit = reg_addr[11:8] == 4'h0 && reg_addr[4:0] == 5'h00
    && dsel < NDESC;
  assign ctl_hit = reg_addr[11:8] == 4'h0 && reg_addr[4:0] == 5'h10
    && dsel < NDESC;
  assign prog_hit = reg_addr[11:8] == `PROGRESS_BASE >> 8
    && reg_addr[7] == 1'b0 && reg_addr[3:0] == 4'h0 && psel < NDESC;

  // ------------------------------------------------------------
  // per-descriptor trackers
  // ------------------------------------------------------------
  generate
    for (g = 0; g < NDESC; g = g + 1)
    begin : chan
      dma_channel #(
        .H2C(g >= NC2H ? 1 : 0),
        .REPLAY(g == CHAN_COUNT ? 1 : 0)
      ) u_chan (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .start(start_r[g]),
        .enable(en_r[g]),
        .ring(ring_r[g]),
        .base(base_r[g]),
        .limit(limit_r[g]),
        .host_ptr(hptr_r[g]),
        .step(tlp_done && busy_r && cur_r == g),
        .step_bytes({size_r[g], 2'b00}),
        .pos_r(pos_w[g]),
        .eng_par_r(epar_w[g]),
        .host_par_r(hpar_w[g]),
        .done_r(done_w[g]),
        .finish_r(finish_w[g]),
        .allow(allow_w[g])
      );
      if (g < NC2H)
      begin : c2h_src
        assign src_ok[g] = ~upstream_fifo_nearly_empty[g];
      end
      else
      begin : h2c_src
        assign src_ok[g] = host_to_card_fifo_ready;
      end
    end
    for (g = NDESC; g < `MAX_DESC; g = g + 1)
    begin : unused
      assign pos_w[g] = 64'h0;
    end
  endgenerate

  assign finish_mask = {{(8-NDESC){1'b0}}, finish_w};

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      for (i = 0; i < `MAX_DESC; i = i + 1)
      begin
        base_r[i] <= 64'h0;
        limit_r[i] <= 64'h0;
        hptr_r[i] <= 64'h0;
        ring_r[i] <= 1'b0;
        size_r[i] <= 11'h000;
      end
      en_r <= `ENABLE_MASK_RESET;
      start_r <= 8'h00;
      inject_r <= 1'b0;
      inject_vec_r <= {IRQ_W{1'b0}};
    end
    else
    begin
      start_r <= 8'h00;
      inject_r <= 1'b0;
      en_r <= en_r & ~finish_mask;
      if (reg_wr && win_hit)
      begin
        base_r[dsel] <= reg_wdata[63:0];
        limit_r[dsel] <= reg_wdata[127:64];
      end
      if (reg_wr && ctl_hit)
      begin
        hptr_r[dsel] <= reg_wdata[127:64];
        ring_r[dsel] <= reg_wdata[`RING_BIT];
        size_r[dsel] <= reg_wdata[`SIZE_MSB:0];
      end
      if (reg_wr && reg_addr == `ENABLE_MASK_ADDR)
      begin
        en_r <= reg_wdata[7:0] & ((8'h01 << NDESC) - 8'h01);
        start_r <= reg_wdata[7:0] & ~en_r;
      end
      if (reg_wr && reg_addr == `IRQ_INJECT_ADDR)
      begin
        inject_r <= 1'b1;
        inject_vec_r <= reg_wdata[IRQ_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // register reads
  // ------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      reg_rdata <= 128'h0;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      reg_rdata <= 128'h0;
      if (reg_rd && ctl_hit)
      begin
        reg_rdata[127:64] <= hptr_r[dsel];
        reg_rdata[`RING_BIT] <= ring_r[dsel];
        reg_rdata[`DIR_BIT] <= dsel >= NC2H;
        reg_rdata[`SIZE_MSB:0] <= size_r[dsel];
      end
      else if (reg_rd && prog_hit)
      begin
        reg_rdata[`HPAR_BIT] <= hpar_w[psel];
        reg_rdata[`EPAR_BIT] <= epar_w[psel];
        reg_rdata[`DONE_BIT] <= done_w[psel];
        reg_rdata[63:0] <= pos_w[psel];
      end
      else if (reg_rd && reg_addr == `ENABLE_MASK_ADDR)
        reg_rdata[7:0] <= en_r;
    end
  end

  // ------------------------------------------------------------
  // scheduler
  // ------------------------------------------------------------
  always @*
  begin
    found = 1'b0;
    pick = 3'h0;
    for (j = NDESC - 1; j >= 0; j = j - 1)
      if (allow_w[j] && src_ok[j] && !start_r[j])
      begin
        found = 1'b1;
        pick = j[2:0];
      end
  end

  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      busy_r <= 1'b0;
      cur_r <= 3'h0;
      tlp_req_valid <= 1'b0;
      tlp_req_chan <= 3'h0;
      tlp_req_addr <= 64'h0;
      tlp_req_words <= 11'h000;
      tlp_req_h2c <= 1'b0;
    end
    else if (busy_r)
    begin
      if (tlp_done)
      begin
        busy_r <= 1'b0;
        tlp_req_valid <= 1'b0;
      end
    end
    else if (found)
    begin
      busy_r <= 1'b1;
      cur_r <= pick;
      tlp_req_valid <= 1'b1;
      tlp_req_chan <= pick;
      tlp_req_addr <= pos_w[pick];
      tlp_req_words <= size_r[pick];
      tlp_req_h2c <= pick >= NC2H;
    end
  end

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  irq_gen #(
    .NSRC(NC2H),
    .VECTORS(IRQ_VECTORS),
    .VW(IRQ_W)
  ) u_irq (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .nearly_empty(upstream_fifo_nearly_empty),
    .any_write(reg_wr),
    .inject(inject_r),
    .inject_vec(inject_vec_r),
    .irq_valid_r(irq_valid),
    .irq_vector_r(irq_vector)
  );
endmodule // pcie_descriptor_ring_dma

/* File: dma_defs.vh */
/*
  address map, field positions and reset values of the descriptor dma.
  assumes a 12-bit byte address on the register port.
*/
`ifndef DMA_DEFS_VH
`define DMA_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define WINDOW_BASE 12'h000
`define CONTROL_BASE 12'h010
`define DESC_STRIDE 12'h020
`define PROGRESS_BASE 12'h200
`define PROGRESS_STRIDE 12'h010
`define ENABLE_MASK_ADDR 12'h400
`define IRQ_INJECT_ADDR 12'h410

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define MAX_DESC 8
`define RING_BIT 12
`define DIR_BIT 11
`define SIZE_MSB 10
`define HPAR_BIT 66
`define EPAR_BIT 65
`define DONE_BIT 64
`define BYTES_PER_WORD_SHIFT 2

// ------------------------------------------------------------
// reset values and parameter defaults
// ------------------------------------------------------------
`define ENABLE_MASK_RESET 8'h00
`define IRQ_VECTORS_DEFAULT 8
`define CHAN_COUNT_DEFAULT 5

`endif

/* File: dma_channel.v */
/*
  pointer and lap-parity tracker for one descriptor.
  assumes step is a one-cycle pulse per completed tlp.
*/
`timescale 1ns/1ps
`include "dma_defs.vh"

module dma_channel #(
  parameter H2C = 0,
  parameter REPLAY = 0
) (
  input wire ref_clk,
  input wire rstn,
  input wire start,
  input wire enable,
  input wire ring,
  input wire [63:0] base,
  input wire [63:0] limit,
  input wire [63:0] host_ptr,
  input wire step,
  input wire [12:0] step_bytes,
  output reg [63:0] pos_r,
  output reg eng_par_r,
  output reg host_par_r,
  output reg done_r,
  output reg finish_r,
  output wire allow
);
  reg [63:0] prev_ptr_r;
  wire [63:0] pos_nxt;
  wire ahead;
  wire par_eq;
  wire ring_ok;

  assign pos_nxt = pos_r + {51'h0, step_bytes};
  assign ahead = pos_nxt <= host_ptr;
  assign par_eq = eng_par_r == host_par_r;

  // ------------------------------------------------------------
  // ring flow control
  // ------------------------------------------------------------
  assign ring_ok = (REPLAY != 0) ? 1'b1 :
    (H2C != 0) ? (par_eq ? ahead : 1'b1) :
    (par_eq ? 1'b1 : ahead);
  assign allow = enable & ~done_r & (~ring | ring_ok);

  // ------------------------------------------------------------
  // position and parity
  // ------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      pos_r <= 64'h0;
      eng_par_r <= 1'b0;
      host_par_r <= 1'b0;
      done_r <= 1'b0;
      finish_r <= 1'b0;
      prev_ptr_r <= 64'h0;
    end
    else
    begin
      finish_r <= 1'b0;
      prev_ptr_r <= host_ptr;
      if (host_ptr < prev_ptr_r)
        host_par_r <= ~host_par_r;
      if (start)
      begin
        pos_r <= base;
        eng_par_r <= 1'b0;
        host_par_r <= 1'b0;
        done_r <= 1'b0;
      end
      else if (step)
      begin
        if (pos_nxt >= limit)
        begin
          if (ring)
          begin
            pos_r <= base;
            eng_par_r <= ~eng_par_r;
          end
          else
          begin
            pos_r <= limit;
            done_r <= 1'b1;
            finish_r <= 1'b1;
          end
        end
        else
          pos_r <= pos_nxt;
      end
    end
  end
endmodule // dma_channel

/* File: irq_gen.v */
/*
  msi-x vector request generator with a global re-arm.
  assumes the fifo flags are on ref_clk.
*/
`timescale 1ns/1ps
`include "dma_defs.vh"

module irq_gen #(
  parameter NSRC = 4,
  parameter VECTORS = 8,
  parameter VW = 3
) (
  input wire ref_clk,
  input wire rstn,
  input wire [NSRC-1:0] nearly_empty,
  input wire any_write,
  input wire inject,
  input wire [VW-1:0] inject_vec,
  output reg irq_valid_r,
  output reg [VW-1:0] irq_vector_r
);
  reg [NSRC-1:0] prev_r;
  reg [NSRC-1:0] pend_r;
  reg [NSRC-1:0] pend_nxt;
  reg [NSRC-1:0] fire_mask;
  reg [VW-1:0] sel;
  reg found;
  reg armed_r;
  integer i;

  // ------------------------------------------------------------
  // pick lowest pending vector
  // ------------------------------------------------------------
  always @*
  begin
    found = 1'b0;
    sel = {VW{1'b0}};
    fire_mask = {NSRC{1'b0}};
    for (i = NSRC - 1; i >= 0; i = i - 1)
      if (pend_r[i])
      begin
        found = 1'b1;
        sel = i[VW-1:0];
      end
    for (i = 0; i < NSRC; i = i + 1)
      if (armed_r && found && !inject && sel == i[VW-1:0])
        fire_mask[i] = 1'b1;
    // set wins over clear
    pend_nxt = (pend_r & ~fire_mask) | (prev_r & ~nearly_empty);
  end

  always @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      prev_r <= {NSRC{1'b0}};
      pend_r <= {NSRC{1'b0}};
      armed_r <= 1'b1;
      irq_valid_r <= 1'b0;
      irq_vector_r <= {VW{1'b0}};
    end
    else
    begin
      prev_r <= nearly_empty;
      pend_r <= pend_nxt;
      irq_valid_r <= 1'b0;
      if (inject)
      begin
        irq_valid_r <= 1'b1;
        irq_vector_r <= inject_vec;
      end
      else if (armed_r && found)
      begin
        irq_valid_r <= 1'b1;
        irq_vector_r <= sel;
        armed_r <= 1'b0;
      end
      if (any_write)
        armed_r <= 1'b1;
    end
  end
endmodule // irq_gen

/* File: dma_checker_properties.sv */
/*
  port-level checks for the descriptor dma top module.
  assumes one clock, ref_clk, and synchronous active-low rstn.
*/
`timescale 1ns/1ps

module dma_checker #(
  parameter CHAN_COUNT = 5,
  parameter IRQ_W = 3
) (
  input wire ref_clk,
  input wire rstn,
  input wire reg_wr,
  input wire reg_rd,
  input wire [11:0] reg_addr,
  input wire [127:0] reg_wdata,
  input wire [127:0] reg_rdata,
  input wire reg_rvalid,
  input wire tlp_req_valid,
  input wire [2:0] tlp_req_chan,
  input wire [63:0] tlp_req_addr,
  input wire [10:0] tlp_req_words,
  input wire tlp_req_h2c,
  input wire tlp_done,
  input wire irq_valid,
  input wire [IRQ_W-1:0] irq_vector
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  property p_read_answer;
    reg_rd |=> reg_rvalid;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered");
  property p_rvalid_cause;
    reg_rvalid |-> $past(reg_rd);
  endproperty
  a_rvalid_cause: assert property (p_rvalid_cause)
    else $error("read answer without read");
  property p_rdata_idle;
    !reg_rvalid |-> reg_rdata == 128'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not cleared");
  // ------------------------------------------------------------
  // tlp requests
  // ------------------------------------------------------------
  property p_req_hold;
    tlp_req_valid && !tlp_done |=> tlp_req_valid && $stable(tlp_req_addr)
      && $stable(tlp_req_chan) && $stable(tlp_req_words);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("request dropped or changed");
  property p_req_release;
    tlp_req_valid && tlp_done |=> !tlp_req_valid;
  endproperty
  a_req_release: assert property (p_req_release)
    else $error("request not released");
  property p_dir_by_index;
    tlp_req_valid |-> tlp_req_h2c == (tlp_req_chan >= CHAN_COUNT - 1);
  endproperty
  a_dir_by_index: assert property (p_dir_by_index)
    else $error("direction does not match index");
  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  property p_irq_single;
    irq_valid && !$past(reg_wr) && !$past(reg_wr, 2) |=> !irq_valid;
  endproperty
  a_irq_single: assert property (p_irq_single)
    else $error("back to back interrupts");
  property p_irq_quiet;
    (!reg_wr)[*3] ##1 (irq_valid && !reg_wr) ##1 (!reg_wr)[*3]
      |=> !irq_valid;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt without re-arm");
  property p_inject;
    reg_wr && reg_addr == 12'h410 |-> ##2 irq_valid
      && irq_vector == $past(reg_wdata[IRQ_W-1:0], 2);
  endproperty
  a_inject: assert property (p_inject)
    else $error("injected interrupt missing");
endmodule // dma_checker

bind pcie_descriptor_ring_dma dma_checker #(
  .CHAN_COUNT(CHAN_COUNT),
  .IRQ_W(IRQ_W)
) u_chk (
  .ref_clk(ref_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .tlp_req_valid(tlp_req_valid),
  .tlp_req_chan(tlp_req_chan), .tlp_req_addr(tlp_req_addr),
  .tlp_req_words(tlp_req_words), .tlp_req_h2c(tlp_req_h2c),
  .tlp_done(tlp_done), .irq_valid(irq_valid), .irq_vector(irq_vector)
);

/* File: host_mem_model.sv */
/*
  host memory side: completes each tlp request after a delay.
  assumes requests are held until the completion pulse.
*/
`timescale 1ns/1ps

module host_mem_model (
  input wire ref_clk,
  input wire rstn,
  input wire tlp_req_valid,
  input wire slow,
  output reg tlp_done
);
  reg [2:0] cnt_r;
  // ------------------------------------------------------------
  // completion after 2 or 6 cycles
  // ------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    tlp_done <= 1'b0;
    if (!rstn)
      cnt_r <= 3'h0;
    else if (tlp_req_valid && !tlp_done)
    begin
      if (cnt_r == (slow ? 3'h5 : 3'h1))
      begin
        tlp_done <= 1'b1;
        cnt_r <= 3'h0;
      end
      else
        cnt_r <= cnt_r + 3'h1;
    end
  end
endmodule // host_mem_model

/* File: pcie_descriptor_ring_dma_tb_top.sv */
/*
  register-level tests of the descriptor dma.
  assumes default channel count 5 and the host memory model.
*/
`timescale 1ns/1ps

module pcie_descriptor_ring_dma_tb_top;
  reg ref_clk, rstn, reg_wr, reg_rd, fifo_ready, slow;
  reg [11:0] reg_addr;
  reg [127:0] reg_wdata, rv;
  reg [3:0] fifo_ne;
  wire [127:0] reg_rdata;
  wire reg_rvalid, tlp_req_valid, tlp_req_h2c, tlp_done, irq_valid;
  wire [2:0] tlp_req_chan, irq_vector;
  wire [63:0] tlp_req_addr;
  wire [10:0] tlp_req_words;
  integer failures, tests_run, cycles, n_req, n_irq, n0;
  reg [63:0] last_addr;
  reg [2:0] last_vec;
  reg [14:0] last_req;
  localparam [127:0] ALL = {128{1'b1}};

  pcie_descriptor_ring_dma DUT (
    .ref_clk(ref_clk), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .upstream_fifo_nearly_empty(fifo_ne),
    .host_to_card_fifo_ready(fifo_ready), .tlp_req_valid(tlp_req_valid),
    .tlp_req_chan(tlp_req_chan), .tlp_req_addr(tlp_req_addr),
    .tlp_req_words(tlp_req_words), .tlp_req_h2c(tlp_req_h2c),
    .tlp_done(tlp_done), .irq_valid(irq_valid), .irq_vector(irq_vector)
  );
  host_mem_model u_host (.ref_clk(ref_clk), .rstn(rstn),
    .tlp_req_valid(tlp_req_valid), .slow(slow), .tlp_done(tlp_done));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ------------------------------------------------------------
  // monitor and timeout
  // ------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (tlp_req_valid && tlp_done)
    begin
      n_req <= n_req + 1;
      last_addr <= tlp_req_addr;
      last_req <= {tlp_req_h2c, tlp_req_chan, tlp_req_words};
    end
    if (irq_valid)
    begin
      n_irq <= n_irq + 1;
      last_vec <= irq_vector;
    end
    if (cycles == 20000)
    begin
      failures = failures + 1;
      give_verdict;
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task give_verdict;
  begin
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  task chk(input [127:0] seen, input [127:0] exp);
  begin
    tests_run = tests_run + 1;
    if (seen !== exp)
    begin
      failures = failures + 1;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task wr(input [11:0] a, input [127:0] d);
  begin
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  end
  endtask
  task rd(input [11:0] a);
  begin
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    chk(reg_rvalid, 1'b1);
    @(posedge ref_clk);
  end
  endtask
  task rdchk(input [11:0] a, input [127:0] m, input [127:0] e);
  begin
    rd(a);
    chk(rv & m, e);
  end
  endtask
  task setup(input [2:0] i, input [63:0] b, input [63:0] l,
             input [63:0] hp, input ring);
  begin
    wr({4'h0, i, 5'h00}, {l, b});
    wr({4'h0, i, 5'h10}, {hp, 51'h0, ring, 1'b0, 11'h004});
  end
  endtask
  task wait_idle;
    integer k;
  begin
    k = 0;
    rd(12'h400);
    while (rv[7:0] !== 8'h00 && k < 60)
    begin
      rd(12'h400);
      k = k + 1;
    end
  end
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    {rstn, reg_wr, reg_rd, slow} = 4'h0;
    fifo_ready = 1'b1;
    fifo_ne = 4'hf;
    reg_addr = 12'h0;
    reg_wdata = 128'h0;
    {failures, tests_run, cycles, n_req, n_irq} = 0;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    rdchk(12'h400, ALL, 128'h0);
    wr(12'h010, {64'hab, 51'h0, 2'b11, 11'h7ff});
    rdchk(12'h010, ALL, {64'hab, 51'h0, 2'b10, 11'h7ff});
    rdchk(12'h090, 128'h800, 128'h800);
    rdchk(12'h0b0, 128'h800, 128'h800);
    rdchk(12'h7f0, ALL, 128'h0);
    slow <= 1'b1;
    fifo_ne <= 4'he;
    setup(3'h0, 64'h1000, 64'h1020, 64'h0, 1'b0);
    chk(last_vec, 3'h0);
    rdchk(12'h000, ALL, 128'h0);
    wr(12'h400, 128'h01);
    wait_idle;
    chk(n_req, 2);
    chk(last_addr, 64'h1010);
    chk(last_req, {1'b0, 3'h0, 11'h004});
    rdchk(12'h200, ALL, {61'h0, 3'b001, 64'h1020});
    slow <= 1'b0;
    fifo_ne <= 4'hc;
    setup(3'h1, 64'h2000, 64'h2020, 64'h2000, 1'b1);
    n0 = n_req;
    wr(12'h400, 128'h02);
    repeat (60) @(posedge ref_clk);
    chk(n_req - n0, 2);
    rdchk(12'h210, ALL, {61'h0, 3'b010, 64'h2000});
    wr(12'h030, {64'h2010, 51'h0, 2'b10, 11'h004});
    repeat (40) @(posedge ref_clk);
    chk(n_req - n0, 3);
    chk(last_addr, 64'h2000);
    wr(12'h030, {64'h2000, 51'h0, 2'b10, 11'h004});
    rdchk(12'h210, 128'h4 << 64, 128'h4 << 64);
    wr(12'h400, 128'h0);
    repeat (10) @(posedge ref_clk);
    setup(3'h4, 64'h3000, 64'h3020, 64'h3010, 1'b1);
    n0 = n_req;
    fifo_ready <= 1'b0;
    wr(12'h400, 128'h10);
    repeat (20) @(posedge ref_clk);
    chk(n_req - n0, 0);
    fifo_ready <= 1'b1;
    repeat (60) @(posedge ref_clk);
    chk(n_req - n0, 1);
    chk(last_req, {1'b1, 3'h4, 11'h004});
    rdchk(12'h240, 64'hffff, 64'h3010);
    wr(12'h400, 128'h0);
    repeat (10) @(posedge ref_clk);
    setup(3'h5, 64'h4000, 64'h4020, 64'h4000, 1'b1);
    n0 = n_req;
    wr(12'h400, 128'h20);
    repeat (80) @(posedge ref_clk);
    chk(n_req - n0 > 4, 1'b1);
    wr(12'h0b0, {64'h4000, 64'h004});
    wait_idle;
    chk(rv[7:0], 8'h00);
    rdchk(12'h250, {63'h0, 1'b1, 64'hffff}, {63'h0, 1'b1, 64'h4020});
    fifo_ne <= 4'hf;
    repeat (8) @(posedge ref_clk);
    fifo_ne <= 4'hb;
    repeat (8) @(posedge ref_clk);
    chk(last_vec, 3'h2);
    n0 = n_irq;
    fifo_ne <= 4'h3;
    repeat (12) @(posedge ref_clk);
    chk(n_irq - n0, 0);
    wr(12'h7f0, 128'h0);
    repeat (6) @(posedge ref_clk);
    chk(last_vec, 3'h3);
    wr(12'h410, 128'h5);
    repeat (4) @(posedge ref_clk);
    chk(last_vec, 3'h5);
    chk(n_irq - n0, 2);
    give_verdict;
  end
endmodule // pcie_descriptor_ring_dma_tb_top
